// ==== hw/serial_rx_pkg.sv ====
package serial_rx_pkg;

  // ==========================================================================
  // Register map (byte addresses on a 32-bit Avalon-MM slave)
  // ==========================================================================
  localparam logic [3:0] ADDR_BAUD   = 4'h0;
  localparam logic [3:0] ADDR_CTRL   = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_DATA   = 4'hc;

  // ==========================================================================
  // Control field positions
  // ==========================================================================
  localparam int CTL_RX_ON      = 0;
  localparam int CTL_TX_ON      = 1;
  localparam int CTL_WORD_LEN   = 2;
  localparam int CTL_PARITY_ON  = 3;
  localparam int CTL_PARITY_ODD = 4;
  localparam int CTL_RX_IRQ     = 5;
  localparam int CTL_IDLE_KIND  = 6;
  localparam int CTL_IDLE_IRQ   = 7;
  localparam int CTL_SLEEP      = 8;
  localparam int CTL_WAKE_ADDR  = 9;
  localparam int CTL_LOOPBACK   = 10;
  localparam int CTL_WIDTH      = 11;

  // ==========================================================================
  // Status field positions
  // ==========================================================================
  localparam int ST_PARITY  = 0;
  localparam int ST_FRAMING = 1;
  localparam int ST_NOISE   = 2;
  localparam int ST_OVERRUN = 3;
  localparam int ST_IDLE    = 4;
  localparam int ST_FULL    = 5;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int          BAUD_W        = 13;
  localparam int          PRESCALE      = 2;
  localparam int          OVERSAMPLE    = 16;
  localparam logic [3:0]  TICK_LAST     = 4'hf;
  localparam logic [3:0]  TICK_MID      = 4'h7;
  localparam logic [3:0]  TICK_S1       = 4'h7;
  localparam logic [3:0]  TICK_S2       = 4'h8;
  localparam logic [3:0]  TICK_S3       = 4'h9;
  localparam logic [3:0]  FRAME_SHORT   = 4'ha;
  localparam logic [3:0]  FRAME_LONG    = 4'hb;
  localparam logic [3:0]  DATA_SHORT    = 4'h8;
  localparam logic [3:0]  DATA_LONG     = 4'h9;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } rx_state_e;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } avl_req_s;

endpackage

// ==== hw/async_serial_receiver.sv ====
`timescale 1ns/10ps
`default_nettype none

module async_serial_receiver
  import serial_rx_pkg::*;
#(
  parameter int DATA_W = 32
) (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              rx_pin,
  input  wire logic              tx_serial,
  output logic                   tx_pin,
  output logic                   rx_on,
  output logic                   tx_on,
  output logic                   irq
);

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic       rst_s1_r;
  logic       rst_n_r;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // ==========================================================================
  // Bus slave
  // ==========================================================================
  avl_req_s            req;
  logic                ack_r;
  logic [BAUD_W-1:0]   baud_r;
  logic [CTL_WIDTH-1:0] ctl_r;
  logic [8:0]          hold_r;
  logic [5:0]          stat_r;
  logic                armed_r;
  logic                data_rd;
  logic                stat_rd;
  logic                ctl_wr;

  assign req = '{read: avs_read, write: avs_write, address: avs_address,
                 writedata: avs_writedata};
  // One wait cycle per access so each access takes effect exactly once.
  assign avs_waitrequest = (req.read | req.write) & ~ack_r;
  assign data_rd = req.read & ack_r & (req.address == ADDR_DATA);
  assign stat_rd = req.read & ack_r & (req.address == ADDR_STATUS);
  assign ctl_wr  = req.write & ack_r & (req.address == ADDR_CTRL);

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (req.read | req.write) & ~ack_r;
    end
  end

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      avs_readdata <= '0;
    end else if (req.read & ~ack_r) begin
      case (req.address)
        ADDR_BAUD:   avs_readdata <= DATA_W'(baud_r);
        ADDR_CTRL:   avs_readdata <= DATA_W'(ctl_r);
        ADDR_STATUS: avs_readdata <= DATA_W'(stat_r);
        ADDR_DATA:   avs_readdata <= DATA_W'(hold_r);
        default:     avs_readdata <= '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      baud_r <= '0;
    end else if (req.write & ack_r & (req.address == ADDR_BAUD)) begin
      baud_r <= req.writedata[BAUD_W-1:0];
    end
  end

  // ==========================================================================
  // Control register; sleep bit is also cleared by wake-up
  // ==========================================================================
  logic wake_evt;

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctl_r <= '0;
    end else begin
      if (ctl_wr) begin
        ctl_r <= req.writedata[CTL_WIDTH-1:0];
      end
      if (wake_evt) begin
        ctl_r[CTL_SLEEP] <= 1'b0;
      end
    end
  end

  assign rx_on = ctl_r[CTL_RX_ON];
  assign tx_on = ctl_r[CTL_TX_ON];

  // ==========================================================================
  // Baud generator: 16x sampling tick
  // ==========================================================================
  logic [BAUD_W:0] div_cnt_r;
  logic            tick;

  // divide by 2 times divisor
  // A compare, not equality, so a divisor lowered mid-count cannot leave the counter to wrap.
  assign tick = (baud_r != '0) && (div_cnt_r >= {baud_r, 1'b0} - 1'b1);

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      div_cnt_r <= '0;
    end else if (baud_r == '0 || tick) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_r + 1'b1;
    end
  end

  // ==========================================================================
  // Input synchroniser and loopback select
  // ==========================================================================
  logic [2:0] rx_sync_r;
  logic       rx_line_r;
  logic       rx_in;

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rx_sync_r <= 3'h7;
      rx_line_r <= 1'b1;
    end else begin
      rx_sync_r <= {rx_sync_r[1:0], rx_pin};
      if (rx_sync_r[1] == rx_sync_r[2]) begin
        rx_line_r <= rx_sync_r[2];
      end
    end
  end

  assign rx_in  = ctl_r[CTL_LOOPBACK] ? tx_serial : rx_line_r;
  assign tx_pin = ctl_r[CTL_LOOPBACK] ? 1'b1 : tx_serial;

  // ==========================================================================
  // Bit processor
  // ==========================================================================
  rx_state_e  state_r;
  logic [3:0] phase_r;
  logic [3:0] bit_cnt_r;
  logic [2:0] samp_r;
  logic [8:0] shift_r;
  logic       noise_acc_r;
  logic       noisy;
  logic       frame_done;
  logic       stop_ok;
  logic       maj;
  logic       bit_end;
  logic [3:0] data_len;
  logic [3:0] frame_len;

  assign data_len  = ctl_r[CTL_WORD_LEN] ? DATA_LONG : DATA_SHORT;
  assign frame_len = ctl_r[CTL_WORD_LEN] ? FRAME_LONG : FRAME_SHORT;
  assign maj = (samp_r[0] & samp_r[1]) | (samp_r[1] & samp_r[2]) | (samp_r[0] & samp_r[2]);
  // A bit is noisy when its three samples do not all agree.
  assign noisy = (|samp_r) && !(&samp_r);
  assign bit_end    = tick && (phase_r == TICK_LAST);
  assign frame_done = bit_end && (state_r == RX_STOP);
  assign stop_ok    = maj;

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      samp_r <= 3'h7;
    end else if (tick && (phase_r == TICK_S1 || phase_r == TICK_S2 || phase_r == TICK_S3)) begin
      samp_r <= {samp_r[1:0], rx_in};
    end
  end

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r     <= RX_IDLE;
      phase_r     <= '0;
      bit_cnt_r   <= '0;
      shift_r     <= '0;
      noise_acc_r <= 1'b0;
    end else if (!ctl_r[CTL_RX_ON]) begin
      state_r <= RX_IDLE;
      phase_r <= '0;
    end else if (tick) begin
      phase_r <= phase_r + 1'b1;
      case (state_r)
        RX_IDLE: begin
          if (!rx_in) begin
            state_r     <= RX_START;
            phase_r     <= '0;
            noise_acc_r <= 1'b0;
            bit_cnt_r   <= '0;
          end
        end
        RX_START: begin
          if (phase_r == TICK_LAST) begin
            state_r <= maj ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (phase_r == TICK_LAST) begin
            shift_r   <= ctl_r[CTL_WORD_LEN] ? {maj, shift_r[8:1]} : {1'b0, maj, shift_r[7:1]};
            bit_cnt_r <= bit_cnt_r + 1'b1;
            if (bit_cnt_r == data_len - 1'b1) begin
              state_r <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (phase_r == TICK_LAST) begin
            state_r <= RX_IDLE;
          end
        end
        default: state_r <= RX_IDLE;
      endcase
      if (phase_r == TICK_LAST && state_r != RX_IDLE && noisy) begin
        noise_acc_r <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Idle detection
  // ==========================================================================
  logic [3:0] ones_r;
  logic       after_stop_r;
  logic       idle_lock_r;
  logic       idle_det;
  logic       line_bit;

  assign line_bit = bit_end & maj;
  // run length equal to frame size
  assign idle_det = line_bit && (ones_r == frame_len - 1'b1) && !idle_lock_r
                    && (!ctl_r[CTL_IDLE_KIND] || after_stop_r);

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ones_r       <= '0;
      after_stop_r <= 1'b0;
    end else if (bit_end) begin
      if (!maj) begin
        ones_r       <= '0;
        after_stop_r <= 1'b0;
      end else if (frame_done) begin
        ones_r       <= ctl_r[CTL_IDLE_KIND] ? 4'h0 : ones_r + 1'b1;
        after_stop_r <= 1'b1;
      end else if (ones_r != frame_len) begin
        ones_r <= ones_r + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Status flags
  // ==========================================================================
  logic sleep;
  logic xfer;
  logic ovr;
  logic par_bad;
  logic clr;
  logic top_bit;

  assign sleep   = ctl_r[CTL_SLEEP];
  assign top_bit = ctl_r[CTL_WORD_LEN] ? shift_r[8] : shift_r[7];
  assign par_bad = ctl_r[CTL_PARITY_ON] &&
                   ((ctl_r[CTL_WORD_LEN] ? ^shift_r[8:0] : ^shift_r[7:0]) != ctl_r[CTL_PARITY_ODD]);
  assign wake_evt = sleep && (ctl_r[CTL_WAKE_ADDR] ? (frame_done && top_bit) : idle_det);
  assign xfer = frame_done && !(sleep && !wake_evt) && !stat_r[ST_FULL];
  assign ovr  = frame_done && !sleep && stat_r[ST_FULL];
  assign clr  = data_rd && armed_r;

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      armed_r <= 1'b0;
    end else if (stat_rd) begin
      armed_r <= 1'b1;
    end else if (data_rd) begin
      armed_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      hold_r <= '0;
    end else if (xfer) begin
      hold_r <= shift_r;
    end
  end

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      stat_r      <= '0;
      idle_lock_r <= 1'b0;
    end else begin
      if (clr) begin
        stat_r <= '0;
      end
      if (xfer) begin
        stat_r[ST_FULL]    <= 1'b1;
        stat_r[ST_NOISE]   <= noise_acc_r | noisy;
        stat_r[ST_PARITY]  <= par_bad;
        stat_r[ST_FRAMING] <= !stop_ok;
        idle_lock_r        <= 1'b0;
      end
      if (ovr) begin
        stat_r[ST_OVERRUN] <= 1'b1;
      end
      if (idle_det) begin
        idle_lock_r <= 1'b1;
        if (!sleep) begin
          stat_r[ST_IDLE] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Interrupt request
  // ==========================================================================
  // full or idle flag request
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      irq <= 1'b0;
    end else begin
      irq <= !sleep && ((ctl_r[CTL_RX_IRQ] && stat_r[ST_FULL]) ||
                        (ctl_r[CTL_IDLE_IRQ] && stat_r[ST_IDLE]));
    end
  end

endmodule

`default_nettype wire

// ==== dv/serial_rx_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none

module serial_rx_monitor
  import serial_rx_pkg::*;
#(
  parameter int DATA_W = 32
) (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  input  wire logic [DATA_W-1:0] avs_readdata,
  input  wire logic              avs_waitrequest,
  input  wire logic              rx_pin,
  input  wire logic              tx_serial,
  input  wire logic              tx_pin,
  input  wire logic              rx_on,
  input  wire logic              tx_on,
  input  wire logic              irq
);
  // ==========================================================================
  // Shadow registers
  // ==========================================================================
  // The sleep bit is also cleared by hardware, so its shadow is trusted only when it reads zero.
  localparam logic [CTL_WIDTH-1:0] SLP_M = CTL_WIDTH'(1 << CTL_SLEEP);
  logic [CTL_WIDTH-1:0] ctl_r;
  logic [BAUD_W-1:0]    baud_r;
  logic                 req;
  logic                 done_rd;
  logic                 done_wr;

  assign req     = avs_read | avs_write;
  assign done_rd = avs_read & ~avs_waitrequest;
  assign done_wr = avs_write & ~avs_waitrequest;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctl_r  <= '0;
      baud_r <= '0;
    end else begin
      if (done_wr && avs_address == ADDR_CTRL) begin
        ctl_r <= avs_writedata[CTL_WIDTH-1:0];
      end
      if (done_wr && avs_address == ADDR_BAUD) begin
        baud_r <= avs_writedata[BAUD_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("waitrequest low in first access cycle");
  a_answer_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered after one wait state");
  a_rx_on_follow: assert property (rx_on == ctl_r[CTL_RX_ON])
    else $error("rx_on differs from written control");
  a_loop_high: assert property (ctl_r[CTL_LOOPBACK] |-> tx_pin)
    else $error("tx_pin not idle high in loopback");
  a_loop_pass: assert property (!ctl_r[CTL_LOOPBACK] |-> tx_pin == tx_serial)
    else $error("tx_pin not following transmitter");
  a_irq_enable: assert property ($rose(irq) |-> (ctl_r[CTL_RX_IRQ] || ctl_r[CTL_IDLE_IRQ]
    || $past(ctl_r[CTL_RX_IRQ] || ctl_r[CTL_IDLE_IRQ])))
    else $error("interrupt raised with no enable");
  a_irq_full: assert property (done_rd && avs_address == ADDR_STATUS
    && avs_readdata[ST_FULL] && ctl_r[CTL_RX_IRQ] && !ctl_r[CTL_SLEEP] |-> irq)
    else $error("full flag without interrupt");
  a_irq_idle: assert property (done_rd && avs_address == ADDR_STATUS
    && avs_readdata[ST_IDLE] && ctl_r[CTL_IDLE_IRQ] && !ctl_r[CTL_SLEEP] |-> irq)
    else $error("idle flag without interrupt");
  a_baud_back: assert property (done_rd && avs_address == ADDR_BAUD
    |-> avs_readdata == DATA_W'(baud_r))
    else $error("divisor readback wrong");
  a_ctrl_back: assert property (done_rd && avs_address == ADDR_CTRL
    |-> ((avs_readdata[CTL_WIDTH-1:0] ^ ctl_r) & ~SLP_M) == '0
    && avs_readdata[DATA_W-1:CTL_WIDTH] == '0)
    else $error("control readback wrong");

  c_full: cover property (done_rd && avs_address == ADDR_STATUS && avs_readdata[ST_FULL]);
  c_overrun: cover property (done_rd && avs_address == ADDR_STATUS && avs_readdata[ST_OVERRUN]);
  c_loop: cover property (ctl_r[CTL_LOOPBACK] && !tx_serial);
endmodule

bind async_serial_receiver serial_rx_monitor #(.DATA_W(DATA_W)) serial_rx_monitor_i (
  .clock(clock), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .rx_pin(rx_pin), .tx_serial(tx_serial),
  .tx_pin(tx_pin), .rx_on(rx_on), .tx_on(tx_on), .irq(irq)
);

`default_nettype wire

// ==== dv/serial_line_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Remote transmitter driving one serial line
// ==========================================================================
module serial_line_model #(
  parameter int BIT_CLKS    = 32,
  parameter int SETTLE_CLKS = 8
) (
  input  wire logic clock,
  output logic      line
);
  initial line = 1'b1;

  // Frames with a good stop bit follow each other with less than a bit of gap, so one call sequence is one message.
  // message framing kept
  task automatic send(input logic [8:0] data, input int nbits, input logic stop,
                      input logic noisy);
    logic b;
    for (int i = 0; i < nbits + 2; i++) begin
      b = (i == 0) ? 1'b0 : (i <= nbits) ? data[i-1] : stop;
      for (int c = 0; c < BIT_CLKS; c++) begin
        @(posedge clock);
        line <= (noisy && i == 2 && (c == 16 || c == 17)) ? ~b : b;
      end
    end
    if (!stop) begin
      @(posedge clock);
      line <= 1'b1;
      repeat (BIT_CLKS) @(posedge clock);
    end else begin
      // The receiver closes a frame at the end of the stop bit, behind its input pipeline.
      repeat (SETTLE_CLKS) @(posedge clock);
    end
  endtask
endmodule

`default_nettype wire

// ==== dv/async_serial_receiver_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none

module async_serial_receiver_tb_top
  import serial_rx_pkg::*;
;
  localparam logic [31:0] ALL = 32'hffff_ffff,
    RX = 32'h1 << CTL_RX_ON, TX = 32'h1 << CTL_TX_ON, WL = 32'h1 << CTL_WORD_LEN,
    PAR = 32'h1 << CTL_PARITY_ON, ODD = 32'h1 << CTL_PARITY_ODD,
    RIRQ = 32'h1 << CTL_RX_IRQ, IKND = 32'h1 << CTL_IDLE_KIND, IIRQ = 32'h1 << CTL_IDLE_IRQ,
    SLP = 32'h1 << CTL_SLEEP, WAKE = 32'h1 << CTL_WAKE_ADDR, LOOP = 32'h1 << CTL_LOOPBACK,
    PRT = 32'h1 << ST_PARITY, FRM = 32'h1 << ST_FRAMING, NSE = 32'h1 << ST_NOISE,
    OVR = 32'h1 << ST_OVERRUN, IDL = 32'h1 << ST_IDLE, FULL = 32'h1 << ST_FULL,
    ERRS = PRT | FRM | NSE | OVR | FULL;

  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [31:0] q;
  logic        avs_waitrequest, rx_pin, tx_serial, tx_pin, rx_on, tx_on, irq;
  int          n_fail = 0;
  int          compares = 0;

  always #50 clock = ~clock;

  async_serial_receiver async_serial_receiver_i (
    .clock(clock), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_pin(rx_pin), .tx_serial(tx_serial),
    .tx_pin(tx_pin), .rx_on(rx_on), .tx_on(tx_on), .irq(irq)
  );
  // With a divisor of one a bit lasts 32 clocks.
  serial_line_model rem_i (.clock(clock), .line(rx_pin));
  serial_line_model loop_i (.clock(clock), .line(tx_serial));

  task automatic summarize();
    if (n_fail == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Waitrequest and read data are taken at the rising edge, before that edge's updates land.
  task automatic acc(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= we;
    avs_read      <= ~we;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    chk("bus answer", {31'h0, avs_waitrequest}, 32'h0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input string w, input logic [3:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    acc(1'b0, a, 32'h0);
    chk(w, q & m, e);
  endtask

  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    rd("baud reset", ADDR_BAUD, 32'h0, ALL);
    rd("ctrl reset", ADDR_CTRL, 32'h0, ALL);
    rd("status reset", ADDR_STATUS, 32'h0, ALL);
    rd("unmapped", 4'h2, 32'h0, ALL);
    acc(1'b1, ADDR_BAUD, ALL);
    rd("baud width", ADDR_BAUD, 32'h1fff, ALL);
    acc(1'b1, ADDR_BAUD, 32'h1);
    acc(1'b1, ADDR_CTRL, TX);
    rem_i.send(9'h0a5, 8, 1'b1, 1'b0);
    rd("rx off", ADDR_STATUS, 32'h0, FULL);
    acc(1'b1, ADDR_CTRL, RX | RIRQ);
    rem_i.send(9'h0a5, 8, 1'b1, 1'b0);
    rd("full", ADDR_STATUS, FULL, ERRS);
    rd("data", ADDR_DATA, 32'ha5, ALL);
    rd("cleared", ADDR_STATUS, 32'h0, ERRS);
    repeat (2) @(negedge clock);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    rem_i.send(9'h011, 8, 1'b1, 1'b0);
    rem_i.send(9'h022, 8, 1'b0, 1'b0);
    rd("overrun", ADDR_STATUS, FULL | OVR, ERRS);
    rd("kept", ADDR_DATA, 32'h11, ALL);
    rem_i.send(9'h033, 8, 1'b0, 1'b0);
    rd("framing", ADDR_STATUS, FULL | FRM, ERRS);
    rd("frame data", ADDR_DATA, 32'h33, ALL);
    for (int p = 0; p < 2; p++) begin
      acc(1'b1, ADDR_CTRL, RX | PAR | (p[0] ? ODD : 32'h0));
      rem_i.send(9'h083, 8, 1'b1, 1'b0);
      rd("parity", ADDR_STATUS, FULL | (p[0] ? 32'h0 : PRT), ERRS);
      rd("parity data", ADDR_DATA, 32'h83, ALL);
    end
    acc(1'b1, ADDR_CTRL, RX);
    rem_i.send(9'h05a, 8, 1'b1, 1'b1);
    rd("noise", ADDR_STATUS, FULL | NSE, ERRS);
    rd("noise data", ADDR_DATA, 32'h5a, ALL);
    acc(1'b1, ADDR_CTRL, RX | WL);
    rem_i.send(9'h1a5, 9, 1'b1, 1'b0);
    rd("nine bit", ADDR_STATUS, FULL, ERRS);
    rd("nine data", ADDR_DATA, 32'h1a5, ALL);
    for (int k = 0; k < 2; k++) begin
      acc(1'b1, ADDR_CTRL, RX | IIRQ | (k[0] ? IKND : 32'h0));
      acc(1'b0, ADDR_STATUS, 32'h0);
      acc(1'b0, ADDR_DATA, 32'h0);
      rem_i.send(9'h001, 8, 1'b1, 1'b0);
      repeat (288) @(posedge clock);
      rd("idle early", ADDR_STATUS, k[0] ? 32'h0 : IDL, IDL);
      repeat (96) @(posedge clock);
      rd("idle", ADDR_STATUS, IDL, IDL);
      acc(1'b0, ADDR_DATA, 32'h0);
      repeat (2) @(negedge clock);
      chk("idle irq off", {31'h0, irq}, 32'h0);
    end
    repeat (384) @(posedge clock);
    rd("idle once", ADDR_STATUS, 32'h0, IDL);
    acc(1'b1, ADDR_CTRL, RX | SLP | WAKE);
    rem_i.send(9'h005, 8, 1'b1, 1'b0);
    rd("asleep", ADDR_STATUS, 32'h0, ERRS);
    rem_i.send(9'h085, 8, 1'b1, 1'b0);
    rd("addr wake", ADDR_STATUS, FULL, ERRS);
    rd("addr data", ADDR_DATA, 32'h85, ALL);
    rd("addr awake", ADDR_CTRL, 32'h0, SLP);
    acc(1'b1, ADDR_CTRL, RX | SLP);
    rem_i.send(9'h005, 8, 1'b1, 1'b0);
    rd("idle asleep", ADDR_STATUS, 32'h0, ERRS);
    repeat (384) @(posedge clock);
    rd("idle awake", ADDR_CTRL, 32'h0, SLP);
    rem_i.send(9'h042, 8, 1'b1, 1'b0);
    rd("wake full", ADDR_STATUS, FULL, ERRS);
    rd("wake data", ADDR_DATA, 32'h42, ALL);
    acc(1'b1, ADDR_CTRL, RX | TX);
    acc(1'b1, ADDR_CTRL, RX | TX | LOOP);
    @(negedge clock);
    chk("tx_on pin", {31'h0, tx_on}, 32'h1);
    loop_i.send(9'h03c, 8, 1'b1, 1'b0);
    rd("loop full", ADDR_STATUS, FULL, ERRS);
    rd("loop data", ADDR_DATA, 32'h3c, ALL);
    summarize();
  end

  initial begin
    repeat (30000) @(posedge clock);
    n_fail++;
    summarize();
  end
endmodule

`default_nettype wire
